// ===== hdl/atfsc_core.sv
// task file drive/head, status, alternate status and command interpreter
//
// Overview of operation
// - drive/head bit 6 selects CHS or LBA
// - LBA built from sector, cylinders, head field
// - respond only when drive bit matches strap
// - head number from bits 3..0, MSB first
// - status read clears level interrupt in I/O mode
// - busy set while operating; others invalid
// - read/write/seek need ready and seek complete
// - write fault sets status bit 5
// - seek completion sets status bit 4
// - data request while transferring, cleared by command
// - corrected data error sets status bit 2
// - index bit always reads zero
// - error set on failure, cleared by next command
// - alternate status same, interrupt left alone
// - 91H uses sector count, drive, head only
// - control bit 1 enables or masks interrupt
// - error register valid only after busy clears
`timescale 1ns/1ps
module atfsc_core
   import atfsc_pkg::*;
#(
   parameter int XFER_WORDS = 256
)(
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic [2:0] reg_addr,
   input  wire logic       alt_sel,
   input  wire logic       reg_rd,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   input  wire logic       drive_number_strap,
   input  wire logic       io_level_mode,
   input  wire logic       data_xfer,
   input  wire logic       media_write_fault,
   input  wire logic       media_corrected,
   input  wire logic       media_error,
   output logic            irq_out,
   output logic [27:0]     block_address,
   output logic            lba_mode,
   output logic [3:0]      head_select_field,
   output logic [7:0]      active_command,
   output logic [6:0]      active_params,
   output logic            cmd_start
);
   // strap pin: three flops, taken when stages two and three agree
   logic [2:0] strap_sync;

   logic       strap_q;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         strap_sync <= 3'h0;
         strap_q    <= 1'b0;
      end else begin
         strap_sync <= {strap_sync[1:0], drive_number_strap};

         if (strap_sync[2] == strap_sync[1]) begin
            strap_q <= strap_sync[2];
         end
      end
   end

   // task file parameter registers
   logic [7:0] drive_head_select;
   logic [7:0] scount, snum, cyl_lo, cyl_hi, feature, dev_ctrl, error_reg;
   logic       wr_std, rd_std, wr_alt, rd_alt;
   logic       selected;
   logic       srst;

   assign wr_std = reg_wr && !alt_sel;
   assign rd_std = reg_rd && !alt_sel;
   assign wr_alt = reg_wr && alt_sel && (reg_addr == OFS_DRV_HEAD);
   assign rd_alt = reg_rd && alt_sel && (reg_addr == OFS_DRV_HEAD);
   assign selected = (drive_head_select[DH_DRV] == strap_q);
   assign srst     = dev_ctrl[DC_SRST];

   atfsc_state_t state, next_state;
   logic         cmd_wr;

   assign cmd_wr = wr_std && (reg_addr == OFS_STATUS) && selected
                   && (state != ATFSC_BUSY) && !srst;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         drive_head_select <= RST_DRV_HEAD;
         scount            <= RST_SCOUNT;
         snum              <= RST_SNUM;
         cyl_lo            <= RST_ZERO;
         cyl_hi            <= RST_ZERO;
         feature           <= RST_ZERO;
      end else if (wr_std && state != ATFSC_BUSY) begin
         case (reg_addr)
            OFS_ERROR:    feature <= reg_wdata;
            OFS_SCOUNT:   scount <= reg_wdata;
            OFS_SNUM:     snum <= reg_wdata;
            OFS_CYL_LO:   cyl_lo <= reg_wdata;
            OFS_CYL_HI:   cyl_hi <= reg_wdata;
            // bits 7 and 5 kept as written; they steer nothing
            OFS_DRV_HEAD: drive_head_select <= reg_wdata;
            default:      ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dev_ctrl <= RST_ZERO;
      end else if (wr_alt) begin
         dev_ctrl <= reg_wdata;
      end
   end

   // command decode
   atfsc_cls_t dec_cls;
   logic [6:0] dec_use;

   atfsc_decode u_decode (
      .code      (reg_wdata),
      .cls       (dec_cls),
      .param_use (dec_use)
   );

   // status flags
   logic       bsy, drdy, dwf, dsc, drq, corr, err;
   logic [7:0] status;

   logic [15:0] busy_cnt;
   logic [8:0]  xfer_cnt;
   atfsc_cls_t  cur_cls;
   logic        media_ok;

   assign media_ok = drdy && dsc;
   assign status = {bsy, drdy, dwf, dsc, drq, corr, 1'b0, err};

   always_comb begin
      next_state = state;
      case (state)
         ATFSC_IDLE: if (cmd_wr) next_state = ATFSC_BUSY;
         ATFSC_BUSY: begin
            if (busy_cnt == 16'h0000) begin
               if (cur_cls == ATFSC_CLS_READ || cur_cls == ATFSC_CLS_WRITE) begin
                  next_state = ATFSC_XFER;
               end else begin
                  next_state = ATFSC_DONE;
               end
            end
         end
         ATFSC_XFER: begin
            if (cmd_wr) next_state = ATFSC_BUSY;
            else if (media_error || (data_xfer && xfer_cnt == 9'h001)) begin
               next_state = ATFSC_DONE;
            end
         end
         ATFSC_DONE: next_state = cmd_wr ? ATFSC_BUSY : ATFSC_IDLE;
         default:    next_state = ATFSC_IDLE;
      endcase

      if (srst) next_state = ATFSC_IDLE;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state <= ATFSC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // command capture and busy timing
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         active_command <= RST_ZERO;
         active_params  <= 7'h00;
         cur_cls        <= ATFSC_CLS_NODATA;
         busy_cnt       <= 16'h0000;
         cmd_start      <= 1'b0;
      end else begin
         cmd_start <= 1'b0;

         if (cmd_wr) begin
            active_command <= reg_wdata;
            active_params  <= dec_use;
            busy_cnt       <= 16'(BUSY_CYCLES - 1);
            cmd_start      <= (dec_cls != ATFSC_CLS_BAD);
            // media commands refused unless ready and seek complete
            if ((dec_cls == ATFSC_CLS_READ || dec_cls == ATFSC_CLS_WRITE
                 || dec_cls == ATFSC_CLS_SEEK) && !media_ok) begin
               cur_cls <= ATFSC_CLS_BAD;
               cmd_start <= 1'b0;
            end else begin
               cur_cls <= dec_cls;
            end
         end else if (state == ATFSC_BUSY && busy_cnt != 16'h0000) begin
            busy_cnt <= busy_cnt - 16'h0001;
         end
      end
   end

   // busy follows the engine; other bits meaningless while it is set
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         bsy <= 1'b0;
      end else begin
         bsy <= (next_state == ATFSC_BUSY) || srst;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         drdy <= 1'b1;
         dsc  <= 1'b1;
      end else begin
         drdy <= !srst;

         if (cmd_wr && dec_cls == ATFSC_CLS_SEEK) begin
            dsc <= 1'b0;
         end else if (state == ATFSC_BUSY && next_state != ATFSC_BUSY) begin
            dsc <= 1'b1;
         end
      end
   end

   // data request and word count
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         drq      <= 1'b0;
         xfer_cnt <= 9'h000;
      end else begin
         if (cmd_wr || srst) begin
            drq <= 1'b0;
         end else begin
            drq <= (next_state == ATFSC_XFER);
         end

         if (state == ATFSC_BUSY) begin
            xfer_cnt <= 9'(XFER_WORDS);
         end else if (state == ATFSC_XFER && data_xfer) begin
            xfer_cnt <= xfer_cnt - 9'h001;
         end
      end
   end

   // fault, correction and error flags: a new event beats the command clear
   logic fail_now;

   assign fail_now = (state == ATFSC_BUSY && busy_cnt == 16'h0000 && cur_cls == ATFSC_CLS_BAD)
                     || (state == ATFSC_XFER && media_error);
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dwf       <= 1'b0;
         corr      <= 1'b0;
         err       <= 1'b0;
         error_reg <= RST_ZERO;
      end else begin
         if (media_write_fault) dwf <= 1'b1;
         else if (cmd_wr)       dwf <= 1'b0;

         if (media_corrected)   corr <= 1'b1;
         else if (cmd_wr)       corr <= 1'b0;

         if (fail_now) begin
            err <= 1'b1;
            if (cur_cls == ATFSC_CLS_BAD) begin
               error_reg[ER_ABRT] <= 1'b1;
            end
         end else if (cmd_wr || srst) begin
            err       <= 1'b0;
            error_reg <= RST_ZERO;
         end
      end
   end

   // interrupt: raised when busy ends, cleared by a new command or by status read in level mode
   logic irq_pend;

   logic rd_status;

   assign rd_status = rd_std && (reg_addr == OFS_STATUS) && selected;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_pend <= 1'b0;
      end else if (state == ATFSC_BUSY && next_state != ATFSC_BUSY) begin
         irq_pend <= 1'b1;
      end else if (cmd_wr || srst) begin
         irq_pend <= 1'b0;
      end else if (rd_status && io_level_mode) begin
         irq_pend <= 1'b0;
      end
      // alternate status read never touches irq_pend
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= irq_pend && !dev_ctrl[DC_NIEN] && selected;
      end
   end

   // read data, registered
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= RST_ZERO;
      end else if (rd_alt) begin
         reg_rdata <= selected ? status : RST_ZERO;
      end else if (rd_std && !selected) begin
         reg_rdata <= RST_ZERO;
      end else if (rd_std) begin
         case (reg_addr)
            // error contents held until busy clears
            OFS_ERROR:    reg_rdata <= bsy ? RST_ZERO : error_reg;
            OFS_SCOUNT:   reg_rdata <= scount;
            OFS_SNUM:     reg_rdata <= snum;
            OFS_CYL_LO:   reg_rdata <= cyl_lo;
            OFS_CYL_HI:   reg_rdata <= cyl_hi;
            OFS_DRV_HEAD: reg_rdata <= drive_head_select;
            OFS_STATUS:   reg_rdata <= status;
            default:      reg_rdata <= RST_ZERO;
         endcase
      end
   end

   // address outputs
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         block_address     <= 28'h0000000;
         lba_mode          <= 1'b0;
         head_select_field <= 4'h0;
      end else begin
         lba_mode          <= drive_head_select[DH_LBA];
         head_select_field <= drive_head_select[DH_HEAD_MSB:0];
         block_address     <= {drive_head_select[DH_HEAD_MSB:0], cyl_hi, cyl_lo, snum};
      end
   end
endmodule // atfsc_core

// ===== hdl/atfsc_pkg.sv
// constants and types for the task file status/command block
package atfsc_pkg;
   // task file register offsets (A2..A0)
   localparam logic [2:0] OFS_DATA     = 3'h0;
   localparam logic [2:0] OFS_ERROR    = 3'h1;
   localparam logic [2:0] OFS_SCOUNT   = 3'h2;
   localparam logic [2:0] OFS_SNUM     = 3'h3;
   localparam logic [2:0] OFS_CYL_LO   = 3'h4;
   localparam logic [2:0] OFS_CYL_HI   = 3'h5;
   localparam logic [2:0] OFS_DRV_HEAD = 3'h6;
   localparam logic [2:0] OFS_STATUS   = 3'h7;
   // drive/head fields
   localparam int DH_OBS_HI   = 7;
   localparam int DH_LBA      = 6;
   localparam int DH_OBS_LO   = 5;
   localparam int DH_DRV      = 4;
   localparam int DH_HEAD_MSB = 3;
   // status fields
   localparam int ST_BSY  = 7;
   localparam int ST_DRDY = 6;
   localparam int ST_DWF  = 5;
   localparam int ST_DSC  = 4;
   localparam int ST_DRQ  = 3;
   localparam int ST_CORR = 2;
   localparam int ST_IDX  = 1;
   localparam int ST_ERR  = 0;
   // error register fields
   localparam int ER_ABRT = 2;
   // device control fields
   localparam int DC_SRST = 2;
   localparam int DC_NIEN = 1;
   // reset values
   localparam logic [7:0] RST_DRV_HEAD = 8'hA0;
   localparam logic [7:0] RST_SCOUNT   = 8'h01;
   localparam logic [7:0] RST_SNUM     = 8'h01;
   localparam logic [7:0] RST_ZERO     = 8'h00;
   // busy time of a non-data command
   localparam int BUSY_NS     = 1000;
   localparam int CLK_PS      = 5000;
   localparam int BUSY_CYCLES = (BUSY_NS * 1000 + CLK_PS - 1) / CLK_PS;
   // command codes
   localparam logic [7:0] CMD_CHK_PWR   = 8'hE5;
   localparam logic [7:0] CMD_CHK_PWR2  = 8'h98;
   localparam logic [7:0] CMD_DIAG      = 8'h90;
   localparam logic [7:0] CMD_ERASE     = 8'hC0;
   localparam logic [7:0] CMD_FORMAT    = 8'h50;
   localparam logic [7:0] CMD_IDENTIFY  = 8'hEC;
   localparam logic [7:0] CMD_IDLE      = 8'hE3;
   localparam logic [7:0] CMD_IDLE2     = 8'h97;
   localparam logic [7:0] CMD_IDLE_IM   = 8'hE1;
   localparam logic [7:0] CMD_IDLE_IM2  = 8'h95;
   localparam logic [7:0] CMD_INIT_PAR  = 8'h91;
   localparam logic [7:0] CMD_RD_BUF    = 8'hE4;
   localparam logic [7:0] CMD_RD_MULT   = 8'hC4;
   localparam logic [7:0] CMD_RD_LONG   = 8'h22;
   localparam logic [7:0] CMD_RD_LONG2  = 8'h23;
   localparam logic [7:0] CMD_RD_SEC    = 8'h20;
   localparam logic [7:0] CMD_RD_SEC2   = 8'h21;
   localparam logic [7:0] CMD_RD_VER    = 8'h40;
   localparam logic [7:0] CMD_RD_VER2   = 8'h41;
   localparam logic [3:0] CMD_RECAL_HI  = 4'h1;
   localparam logic [7:0] CMD_REQ_SENSE = 8'h03;
   localparam logic [3:0] CMD_SEEK_HI   = 4'h7;
   localparam logic [7:0] CMD_SET_FEAT  = 8'hEF;
   localparam logic [7:0] CMD_SET_MULT  = 8'hC6;
   localparam logic [7:0] CMD_SLEEP     = 8'hE6;
   localparam logic [7:0] CMD_SLEEP2    = 8'h99;
   localparam logic [7:0] CMD_STBY      = 8'hE2;
   localparam logic [7:0] CMD_STBY2     = 8'h96;
   localparam logic [7:0] CMD_STBY_IM   = 8'hE0;
   localparam logic [7:0] CMD_STBY_IM2  = 8'h94;
   localparam logic [7:0] CMD_XLATE     = 8'h87;
   // parameter-use mask bits: {lba, hd, dr, cy, sn, sc, fr}
   localparam int PU_FR  = 0;
   localparam int PU_SC  = 1;
   localparam int PU_SN  = 2;
   localparam int PU_CY  = 3;
   localparam int PU_DR  = 4;
   localparam int PU_HD  = 5;
   localparam int PU_LBA = 6;
   localparam logic [6:0] PU_DR_ONLY = 7'h10;
   localparam logic [6:0] PU_DR_SC   = 7'h12;
   localparam logic [6:0] PU_DR_FR   = 7'h11;
   localparam logic [6:0] PU_ALL_SC  = 7'h7E;
   localparam logic [6:0] PU_NO_SC   = 7'h7C;
   localparam logic [6:0] PU_FORMAT  = 7'h7A;
   localparam logic [6:0] PU_INIT    = 7'h32;
   // command classes
   typedef enum logic [2:0] {
      ATFSC_CLS_NODATA = 3'h0,
      ATFSC_CLS_READ   = 3'h1,
      ATFSC_CLS_WRITE  = 3'h2,
      ATFSC_CLS_SEEK   = 3'h3,
      ATFSC_CLS_INIT   = 3'h4,
      ATFSC_CLS_BAD    = 3'h7
   } atfsc_cls_t;
   // command engine states
   typedef enum logic [3:0] {
      ATFSC_IDLE = 4'b0001,
      ATFSC_BUSY = 4'b0010,
      ATFSC_XFER = 4'b0100,
      ATFSC_DONE = 4'b1000
   } atfsc_state_t;
endpackage

// ===== hdl/atfsc_decode.sv
// command code decoder: class and parameter-use mask
`timescale 1ns/1ps
module atfsc_decode
   import atfsc_pkg::*;
(
   input  wire logic [7:0] code,
   output atfsc_cls_t      cls,
   output logic [6:0]      param_use
);
   always_comb begin
      cls       = ATFSC_CLS_NODATA;
      param_use = PU_DR_ONLY;
      // recalibrate and seek ignore the low nibble
      if (code[7:4] == CMD_RECAL_HI) begin
         cls = ATFSC_CLS_SEEK;
      end else if (code[7:4] == CMD_SEEK_HI) begin
         cls       = ATFSC_CLS_SEEK;
         param_use = PU_NO_SC;
      end else begin
         case (code)
            CMD_CHK_PWR, CMD_CHK_PWR2, CMD_DIAG, CMD_IDLE_IM, CMD_IDLE_IM2,
            CMD_REQ_SENSE, CMD_SLEEP, CMD_SLEEP2, CMD_STBY, CMD_STBY2,
            CMD_STBY_IM, CMD_STBY_IM2: begin
               cls = ATFSC_CLS_NODATA;
            end
            CMD_IDLE, CMD_IDLE2, CMD_SET_MULT: begin
               param_use = PU_DR_SC;
            end
            CMD_SET_FEAT: begin
               param_use = PU_DR_FR;
            end
            CMD_INIT_PAR: begin
               cls       = ATFSC_CLS_INIT;
               param_use = PU_INIT;
            end
            CMD_IDENTIFY, CMD_RD_BUF: begin
               cls = ATFSC_CLS_READ;
            end
            CMD_RD_MULT, CMD_RD_SEC, CMD_RD_SEC2: begin
               cls       = ATFSC_CLS_READ;
               param_use = PU_ALL_SC;
            end
            CMD_RD_LONG, CMD_RD_LONG2: begin
               cls       = ATFSC_CLS_READ;
               param_use = PU_NO_SC;
            end
            CMD_RD_VER, CMD_RD_VER2, CMD_ERASE, CMD_XLATE: begin
               cls       = ATFSC_CLS_NODATA;
               param_use = PU_ALL_SC;
            end
            CMD_FORMAT: begin
               cls       = ATFSC_CLS_WRITE;
               param_use = PU_FORMAT;
            end
            default: begin
               cls       = ATFSC_CLS_BAD;
               param_use = PU_DR_ONLY;
            end
         endcase
      end
   end
endmodule // atfsc_decode

// ===== bench/atfsc_core_monitor.sv
// assertion checker for the task file status/command block
`timescale 1ns/1ps
module atfsc_core_monitor
   import atfsc_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic [2:0]  reg_addr,
   input wire logic        alt_sel,
   input wire logic        reg_rd,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        io_level_mode,
   input wire logic        irq_out,
   input wire logic [27:0] block_address,
   input wire logic        lba_mode,
   input wire logic [3:0]  head_select_field,
   input wire logic [7:0]  active_command,
   input wire logic [6:0]  active_params,
   input wire logic        cmd_start
);
   logic dh_wr, dc_wr, cmd_wr, st_rd, nien_q;
   int   gap;
   assign dh_wr  = reg_wr && !alt_sel && reg_addr == OFS_DRV_HEAD;
   assign dc_wr  = reg_wr && alt_sel && reg_addr == OFS_DRV_HEAD;
   assign cmd_wr = reg_wr && !alt_sel && reg_addr == OFS_STATUS;
   assign st_rd  = reg_rd && !alt_sel && reg_addr == OFS_STATUS;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)
         nien_q <= 1'b0;
      else if (dc_wr)
         nien_q <= reg_wdata[DC_NIEN];
   end
   // saturating: never wraps
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)
         gap <= 1000;
      else if (cmd_start)
         gap <= 1;
      else if (gap < 1000)
         gap <= gap + 1;
   end
   default clocking mcb @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_IDX_ZERO: assert property (
      reg_rd && (st_rd || alt_sel && reg_addr == OFS_DRV_HEAD) |=> !reg_rdata[ST_IDX])
      else $error("index bit read as one");
   AST_LBA_FROM_WRITE: assert property (
      !$stable(lba_mode) |-> $past(dh_wr, 2) && $past(reg_wdata[DH_LBA], 2) == lba_mode)
      else $error("mode flag changed without a matching write");
   AST_HEAD_FROM_WRITE: assert property (
      !$stable(head_select_field) |-> $past(dh_wr, 2) &&
      $past(reg_wdata[DH_HEAD_MSB:0], 2) == head_select_field)
      else $error("head field changed without a matching write");
   AST_ADDR_TOP: assert property (
      $stable(head_select_field) [*3] |-> block_address[27:24] == head_select_field)
      else $error("block address top nibble differs from head field");
   AST_CMD_ORIGIN: assert property (
      cmd_start |-> $past(cmd_wr) && active_command == $past(reg_wdata))
      else $error("command start without matching command write");
   AST_BUSY_SPACING: assert property (
      cmd_start |-> gap >= BUSY_CYCLES - 1)
      else $error("command accepted while still busy");
   AST_INIT_PARAMS: assert property (
      cmd_start && active_command == CMD_INIT_PAR |-> active_params == PU_INIT)
      else $error("wrong parameter use for drive parameter setup");
   AST_IRQ_MASKED: assert property (
      $past(nien_q) && nien_q |-> !irq_out)
      else $error("interrupt raised while disabled");
   AST_STATUS_CLEARS_IRQ: assert property (
      st_rd && io_level_mode |-> ##2 !irq_out)
      else $error("status read left interrupt asserted");
   AST_ALT_KEEPS_IRQ: assert property (
      reg_rd && alt_sel && reg_addr == OFS_DRV_HEAD && irq_out && !reg_wr &&
      !$past(reg_rd, 2) && !$past(reg_wr, 2) |=> irq_out [*2])
      else $error("alternate status read dropped interrupt");
   CV_CMD: cover property (cmd_start && active_command == CMD_RD_SEC);
   CV_IRQ_CLR: cover property (st_rd && irq_out);
   CV_MASKED: cover property (nien_q && cmd_start);
endmodule // atfsc_core_monitor

bind atfsc_core atfsc_core_monitor u_atfsc_core_monitor (
   .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .alt_sel(alt_sel),
   .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .io_level_mode(io_level_mode), .irq_out(irq_out),
   .block_address(block_address), .lba_mode(lba_mode),
   .head_select_field(head_select_field), .active_command(active_command),
   .active_params(active_params), .cmd_start(cmd_start));

// ===== bench/atfsc_host.sv
// host register bus model for the task file block
`timescale 1ns/1ps
module atfsc_host
   import atfsc_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   output logic [2:0]      reg_addr = 3'h0,
   output logic            alt_sel = 1'b0,
   output logic            reg_rd = 1'b0,
   output logic            reg_wr = 1'b0,
   output logic [7:0]      reg_wdata = 8'h00
);
   task automatic wr(input logic [2:0] a, input logic alt, input logic [7:0] d);
      logic [7:0] v;
      v = (a == OFS_DRV_HEAD && !alt) ? d | 8'hA0 : d;
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      alt_sel = alt;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b0;
      // released bus must not look valid
      reg_wdata = ~v;
   endtask
   task automatic rd(input logic [2:0] a, input logic alt, output logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      alt_sel = alt;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   // parameters first, command code written last
   task automatic issue(input logic [7:0] dh, sn, cl, ch, code);
      wr(OFS_SCOUNT, 1'b0, 8'h01);
      wr(OFS_SNUM, 1'b0, sn);
      wr(OFS_CYL_LO, 1'b0, cl);
      wr(OFS_CYL_HI, 1'b0, ch);
      wr(OFS_DRV_HEAD, 1'b0, dh);
      wr(OFS_STATUS, 1'b0, code);
   endtask
endmodule // atfsc_host

// ===== bench/ata_task_file_status_command_tb.sv
// self-checking bench for the task file status/command block
`timescale 1ns/1ps
module ata_task_file_status_command_tb
   import atfsc_pkg::*;
;
   localparam int XW = 4;
   logic ref_clk = 1'b0, reset = 1'b1, strap = 1'b0, nien = 1'b0;
   logic data_xfer = 1'b0, wfault = 1'b0, corr = 1'b0, merr = 1'b0;
   logic [2:0] reg_addr;
   logic alt_sel, reg_rd, reg_wr, irq_out, lba_mode, cmd_start;
   logic [7:0] reg_wdata, reg_rdata, active_command, s, dh;
   logic [27:0] block_address;
   logic [3:0] head_select_field;
   logic [6:0] active_params;
   logic [7:0] exp_cmd[$];
   logic [6:0] exp_par[$];
   logic [7:0] codes[] = '{8'hE5, 8'h98, 8'h90, 8'hC0, 8'h50, 8'hEC, 8'hE3, 8'h97, 8'hE1,
      8'h95, 8'h91, 8'hE4, 8'hC4, 8'h22, 8'h23, 8'h20, 8'h21, 8'h40, 8'h41, 8'h13, 8'h03,
      8'h7A, 8'hEF, 8'hC6, 8'hE6, 8'h99, 8'hE2, 8'h96, 8'hE0, 8'h94, 8'h87, 8'h00, 8'hFF};
   int n_mismatch = 0, check_count = 0, cyc = 0;
   always #2.5 ref_clk = ~ref_clk;
   atfsc_core #(.XFER_WORDS(XW)) u_atfsc_core (
      .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .alt_sel(alt_sel),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .drive_number_strap(strap), .io_level_mode(1'b1), .data_xfer(data_xfer),
      .media_write_fault(wfault), .media_corrected(corr), .media_error(merr),
      .irq_out(irq_out), .block_address(block_address), .lba_mode(lba_mode),
      .head_select_field(head_select_field), .active_command(active_command),
      .active_params(active_params), .cmd_start(cmd_start));
   atfsc_host u_atfsc_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .alt_sel(alt_sel), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // reference mask per code, -1 = abort
   function automatic int exp_mask(input logic [7:0] c);
      if (c[7:4] == CMD_SEEK_HI || c == 8'h22 || c == 8'h23)
         return PU_NO_SC;
      case (c)
         8'hC0, 8'hC4, 8'h20, 8'h21, 8'h40, 8'h41, 8'h87: return PU_ALL_SC;
         8'h50: return PU_FORMAT;
         8'h91: return PU_INIT;
         8'hE3, 8'h97, 8'hC6: return PU_DR_SC;
         8'hEF: return PU_DR_FR;
         8'h00, 8'hFF: return -1;
         default: return PU_DR_ONLY;
      endcase
   endfunction
   task automatic pulse(ref logic sig);
      @(posedge ref_clk);
      #1;
      sig = 1'b1;
      @(posedge ref_clk);
      #1;
      sig = 1'b0;
   endtask
   task automatic run_cmd(input logic [7:0] c, input logic [7:0] d, input bit inj);
      int m;
      logic [7:0] sn, cl, ch;
      m = exp_mask(c);
      sn = 8'($urandom);
      cl = 8'($urandom);
      ch = 8'($urandom);
      if (m >= 0) begin
         exp_cmd.push_back(c);
         exp_par.push_back(m[6:0]);
      end
      u_atfsc_host.issue(d, sn, cl, ch, c);
      check({lba_mode, head_select_field, block_address}, {d[6], d[3:0], d[3:0], ch, cl, sn});
      u_atfsc_host.rd(OFS_DRV_HEAD, 1'b1, s);
      check(s[ST_BSY], 1'b1);
      for (int i = 0; i < 400 && s[ST_BSY]; i++)
         u_atfsc_host.rd(OFS_DRV_HEAD, 1'b1, s);
      if (s[ST_DRQ] === 1'b1) begin
         repeat (2) @(posedge ref_clk);
         check(irq_out, !nien);
         u_atfsc_host.rd(OFS_DRV_HEAD, 1'b1, s);
         check(irq_out, !nien);
         u_atfsc_host.rd(OFS_STATUS, 1'b0, s);
         repeat (2) @(posedge ref_clk);
         check({irq_out, s[ST_DRQ]}, 2'b01);
         if (inj)
            pulse(merr);
         else
            repeat (XW) pulse(data_xfer);
         repeat (2) @(posedge ref_clk);
      end
      u_atfsc_host.rd(OFS_STATUS, 1'b0, s);
      check({s[7:6], s[4:3], s[1:0]}, {5'b01100, m < 0 || inj});
      if (m < 0) begin
         u_atfsc_host.rd(OFS_ERROR, 1'b0, s);
         check(s[ER_ABRT], 1'b1);
      end
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cmd_start === 1'b1) begin
         check(exp_cmd.size() > 0, 1'b1);
         if (exp_cmd.size() > 0)
            check({active_command, active_params}, {exp_cmd.pop_front(), exp_par.pop_front()});
      end
      if (cyc == 40000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      void'($urandom(82));
      repeat (20) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      u_atfsc_host.rd(OFS_STATUS, 1'b0, s);
      check(s, 8'h50);
      u_atfsc_host.rd(OFS_DRV_HEAD, 1'b0, s);
      check(s, 8'hA0);
      $display("test reset values done");
      foreach (codes[k]) begin
         dh = 8'($urandom) & 8'hEF;
         run_cmd(codes[k] | (codes[k][7:4] == 4'h1 ? 8'($urandom) & 8'h0F : 8'h00), dh, 1'b0);
      end
      $display("test command sweep done");
      u_atfsc_host.wr(OFS_DRV_HEAD, 1'b1, 8'h0A);
      nien = 1'b1;
      run_cmd(CMD_RD_SEC2, 8'h45, 1'b0);
      u_atfsc_host.wr(OFS_DRV_HEAD, 1'b1, 8'h08);
      nien = 1'b0;
      run_cmd(CMD_RD_SEC, 8'h03, 1'b1);
      run_cmd(CMD_SEEK_HI << 4 | 8'($urandom) & 8'h0F, 8'h4C, 1'b0);
      $display("test interrupt and error done");
      u_atfsc_host.issue(8'h10, 8'h01, 8'h02, 8'h03, CMD_RD_SEC);
      u_atfsc_host.rd(OFS_STATUS, 1'b0, s);
      check(s, 8'h00);
      strap = 1'b1;
      repeat (6) @(posedge ref_clk);
      run_cmd(CMD_CHK_PWR, 8'h1F, 1'b0);
      $display("test drive select done");
      pulse(wfault);
      pulse(corr);
      u_atfsc_host.rd(OFS_STATUS, 1'b0, s);
      check({s[ST_DWF], s[ST_CORR], s[ST_IDX]}, 3'b110);
      check(exp_cmd.size(), 0);
      $display("test media flags done");
      final_report();
   end
endmodule // ata_task_file_status_command_tb
